/* rtw_pkg.sv */
// constants shared by the two-wire slave port of the clock/calendar
// assumes a synthesis flow that accepts systemverilog packages

package rtw_pkg;

    // ****************************************
    // widths
    // ****************************************
    localparam int         RTW_IDX_W     = 4;
    localparam int         RTW_DATA_W    = 8;

    // ****************************************
    // addressing and counts
    // ****************************************
    localparam logic [6:0] RTW_DEV_ADDR  = 7'h2a;  // arbitrary slave address
    localparam logic [3:0] RTW_BYTE_BITS = 4'h8;
    localparam logic [3:0] RTW_CNT_RST   = 4'h0;
    localparam logic [3:0] RTW_IDX_RST   = 4'h0;
    localparam logic [3:0] RTW_IDX_STEP  = 4'h1;

    // ****************************************
    // reset values
    // ****************************************
    localparam logic [2:0] RTW_PIN_RST   = 3'h6;   // scl, sda high; ce low
    localparam logic [7:0] RTW_DATA_RST  = 8'h00;

endpackage : rtw_pkg

/* rtw_sync.sv */
// two flip-flop level synchroniser, any width
// assumes each bit is an independent level from another domain

module rtw_sync #(
    parameter int             W   = 1,
    parameter logic [W-1:0]   RST = '0
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);

    // ****************************************
    // two stages, first read only by second
    // ****************************************
    logic [W-1:0] meta_r;
    logic [W-1:0] hold_r;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_r <= RST;
            hold_r <= RST;
        end else begin
            meta_r <= d;
            hold_r <= meta_r;
        end
    end

    assign q = hold_r;

endmodule : rtw_sync

/* rtw_pulse_sync.sv */
// toggle to pulse crossing into the clock of this module
// assumes the source toggles at most once per several destination cycles

module rtw_pulse_sync (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic ce,
    input  wire logic tgl,
    output logic      pulse
);

    // ****************************************
    // synchroniser and edge memory
    // ****************************************
    logic [1:0] sync_r;
    logic       seen_r;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sync_r <= 2'h0;
        end else begin
            sync_r <= {sync_r[0], tgl};
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            seen_r <= 1'h0;
        end else if (ce) begin
            seen_r <= sync_r[1];
        end
    end

    // held until consumed under ce
    assign pulse = ce & (sync_r[1] ^ seen_r);

endmodule : rtw_pulse_sync

/* rtw_slave_port.sv */
// two-wire serial slave port of a clock/calendar, with register access port
// assumes scl/sda arrive as pins, lnk_clk oversamples them, clk is the core clock

module rtw_slave_port (
    input  wire logic                           clk,
    input  wire logic                           rst_n,
    input  wire logic                           ce,
    input  wire logic                           lnk_clk,
    input  wire logic                           scl_i,
    input  wire logic                           sda_i,
    output logic                                sda_o,
    output logic                                sda_oe,
    output logic [rtw_pkg::RTW_IDX_W-1:0]       reg_idx,
    output logic [rtw_pkg::RTW_DATA_W-1:0]      reg_wdata,
    output logic                                reg_wr,
    output logic                                reg_rd,
    input  wire logic [rtw_pkg::RTW_DATA_W-1:0] reg_rdata
);
    import rtw_pkg::*;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_RX,
        ST_RX_ACK,
        ST_TX,
        ST_TX_ACK
    } rtw_st_e;

    // ****************************************
    // link side pin sampling
    // ****************************************
    logic scl_s;
    logic sda_s;
    logic ce_l;
    logic scl_q_r;
    logic sda_q_r;

    rtw_sync #(
        .W   (3),
        .RST (RTW_PIN_RST)
    ) u_pin_sync (
        .clk   (lnk_clk),
        .rst_n (rst_n),
        .d     ({scl_i, sda_i, ce}),
        .q     ({scl_s, sda_s, ce_l})
    );

    always_ff @(posedge lnk_clk or negedge rst_n) begin
        if (!rst_n) begin
            scl_q_r <= 1'h1;
            sda_q_r <= 1'h1;
        end else if (ce_l) begin
            scl_q_r <= scl_s;
            sda_q_r <= sda_s;
        end
    end

    logic start_evt;
    logic stop_evt;
    logic scl_rise;
    logic scl_fall;

    // change while clock high is a condition, never data
    assign start_evt = ce_l & scl_s & scl_q_r & sda_q_r & ~sda_s;
    assign stop_evt  = ce_l & scl_s & scl_q_r & ~sda_q_r & sda_s;
    assign scl_rise  = ce_l & scl_s & ~scl_q_r;
    assign scl_fall  = ce_l & ~scl_s & scl_q_r;

    // ****************************************
    // link side state
    // ****************************************
    rtw_st_e              st_r;
    logic [3:0]           cnt_r;
    logic [7:0]           sh_r;
    logic [7:0]           tx_r;
    logic [7:0]           rdat_l_r;
    logic [3:0]           idx_r;
    logic                 oe_r;
    logic                 first_r;
    logic                 rd_dir_r;
    logic                 idx_pend_r;
    logic                 nack_r;
    logic                 req_tgl_r;
    logic                 req_rd_r;
    logic [3:0]           req_idx_r;
    logic [7:0]           req_dat_r;
    logic                 ack_p;

    logic       byte_end;
    logic       addr_hit;
    logic       rx_done;
    logic       acc_addr;
    logic       rx_idx;
    logic       rx_wr;
    logic       tx_done;
    logic       ack_end_rx;
    logic       tx_next;
    logic       rd_req;
    logic [3:0] sh_lo;
    logic [3:0] idx_inc;

    assign byte_end   = scl_fall & (cnt_r == RTW_BYTE_BITS);
    assign addr_hit   = (sh_r[7:1] == RTW_DEV_ADDR);
    assign rx_done    = (st_r == ST_RX) & byte_end;
    assign acc_addr   = rx_done & first_r & addr_hit;
    assign rx_idx     = rx_done & ~first_r & idx_pend_r;
    assign rx_wr      = rx_done & ~first_r & ~idx_pend_r;
    assign tx_done    = (st_r == ST_TX) & byte_end;
    assign ack_end_rx = (st_r == ST_RX_ACK) & scl_fall;
    assign tx_next    = (st_r == ST_TX_ACK) & scl_fall & ~nack_r;
    assign rd_req     = (acc_addr & sh_r[0]) | tx_done;
    assign sh_lo      = sh_r[3:0];
    assign idx_inc    = idx_r + RTW_IDX_STEP;

    // ****************************************
    // transfer state machine and data drive
    // ****************************************
    always_ff @(posedge lnk_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r       <= ST_IDLE;
            oe_r       <= 1'h0;
            first_r    <= 1'h0;
            rd_dir_r   <= 1'h0;
            idx_pend_r <= 1'h0;
        end else if (start_evt) begin
            st_r    <= ST_RX;
            oe_r    <= 1'h0;
            first_r <= 1'h1;
        end else if (stop_evt) begin
            st_r <= ST_IDLE;
            oe_r <= 1'h0;
        end else begin
            case (st_r)
                ST_IDLE: begin
                    oe_r <= 1'h0;
                end
                ST_RX: begin
                    if (rx_done) begin
                        if (first_r && !addr_hit) begin
                            st_r <= ST_IDLE;
                        end else begin
                            st_r    <= ST_RX_ACK;
                            oe_r    <= 1'h1;
                            first_r <= 1'h0;
                            if (first_r) begin
                                rd_dir_r   <= sh_r[0];
                                idx_pend_r <= ~sh_r[0];
                            end else begin
                                idx_pend_r <= 1'h0;
                            end
                        end
                    end
                end
                ST_RX_ACK: begin
                    if (scl_fall) begin
                        if (rd_dir_r) begin
                            st_r <= ST_TX;
                            oe_r <= ~rdat_l_r[7];
                        end else begin
                            st_r <= ST_RX;
                            oe_r <= 1'h0;
                        end
                    end
                end
                ST_TX: begin
                    if (byte_end) begin
                        st_r <= ST_TX_ACK;
                        oe_r <= 1'h0;
                    end else if (scl_fall) begin
                        oe_r <= ~tx_r[6];
                    end
                end
                ST_TX_ACK: begin
                    if (scl_fall) begin
                        if (!nack_r) begin
                            st_r <= ST_TX;
                            oe_r <= ~rdat_l_r[7];
                        end else begin
                            st_r <= ST_IDLE;
                            oe_r <= 1'h0;
                        end
                    end
                end
                default: begin
                    st_r <= ST_IDLE;
                    oe_r <= 1'h0;
                end
            endcase
        end
    end

    // ****************************************
    // bit counting and shifting
    // ****************************************
    always_ff @(posedge lnk_clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_r  <= RTW_CNT_RST;
            sh_r   <= RTW_DATA_RST;
            tx_r   <= RTW_DATA_RST;
            nack_r <= 1'h0;
        end else if (start_evt) begin
            cnt_r <= RTW_CNT_RST;
        end else if (scl_rise) begin
            if (st_r == ST_RX || st_r == ST_TX) begin
                cnt_r <= cnt_r + RTW_IDX_STEP;
            end
            if (st_r == ST_RX) begin
                sh_r <= {sh_r[6:0], sda_s};
            end
            if (st_r == ST_TX_ACK) begin
                nack_r <= sda_s;
            end
        end else if (scl_fall) begin
            if (byte_end) begin
                cnt_r <= RTW_CNT_RST;
            end
            if ((ack_end_rx && rd_dir_r) || tx_next) begin
                tx_r <= rdat_l_r;
            end else if (st_r == ST_TX) begin
                tx_r <= {tx_r[6:0], 1'h0};
            end
        end
    end

    // ****************************************
    // register selector
    // ****************************************
    always_ff @(posedge lnk_clk or negedge rst_n) begin
        if (!rst_n) begin
            idx_r <= RTW_IDX_RST;
        end else if (rx_idx) begin
            idx_r <= sh_lo;
        end else if (rx_wr || tx_done) begin
            idx_r <= idx_inc;
        end
    end

    // ****************************************
    // requests toward the core clock
    // ****************************************
    always_ff @(posedge lnk_clk or negedge rst_n) begin
        if (!rst_n) begin
            req_tgl_r <= 1'h0;
            req_rd_r  <= 1'h0;
            req_idx_r <= RTW_IDX_RST;
            req_dat_r <= RTW_DATA_RST;
        end else if (rd_req || rx_wr) begin
            req_tgl_r <= ~req_tgl_r;
            req_rd_r  <= rd_req;
            req_idx_r <= tx_done ? idx_inc : idx_r;
            req_dat_r <= sh_r;
        end
    end

    logic [7:0] rd_hold_r;
    logic       ack_tgl_r;

    rtw_pulse_sync u_ack_sync (
        .clk   (lnk_clk),
        .rst_n (rst_n),
        .ce    (ce_l),
        .tgl   (ack_tgl_r),
        .pulse (ack_p)
    );

    always_ff @(posedge lnk_clk or negedge rst_n) begin
        if (!rst_n) begin
            rdat_l_r <= RTW_DATA_RST;
        end else if (ack_p) begin
            rdat_l_r <= rd_hold_r;
        end
    end

    // ****************************************
    // core clock register access
    // ****************************************
    logic       req_p;
    logic       rd_pend_r;
    logic       sda_lo_r;
    logic       reg_wr_r;
    logic       reg_rd_r;
    logic [3:0] reg_idx_r;
    logic [7:0] reg_wdata_r;

    rtw_pulse_sync u_req_sync (
        .clk   (clk),
        .rst_n (rst_n),
        .ce    (ce),
        .tgl   (req_tgl_r),
        .pulse (req_p)
    );

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_wr_r    <= 1'h0;
            reg_rd_r    <= 1'h0;
            reg_idx_r   <= RTW_IDX_RST;
            reg_wdata_r <= RTW_DATA_RST;
        end else if (ce) begin
            reg_wr_r <= req_p & ~req_rd_r;
            reg_rd_r <= req_p & req_rd_r;
            if (req_p) begin
                reg_idx_r   <= req_idx_r;
                reg_wdata_r <= req_dat_r;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_pend_r <= 1'h0;
            rd_hold_r <= RTW_DATA_RST;
            ack_tgl_r <= 1'h0;
        end else if (ce) begin
            rd_pend_r <= reg_rd_r;
            if (rd_pend_r) begin
                rd_hold_r <= reg_rdata;
                ack_tgl_r <= ~ack_tgl_r;
            end
        end
    end

    // data pin only ever pulls low; no clock output exists
    always_ff @(posedge lnk_clk or negedge rst_n) begin
        if (!rst_n) begin
            sda_lo_r <= 1'h0;
        end else begin
            sda_lo_r <= 1'h0;
        end
    end

    assign sda_o     = sda_lo_r;
    assign sda_oe    = oe_r;
    assign reg_idx   = reg_idx_r;
    assign reg_wdata = reg_wdata_r;
    assign reg_wr    = reg_wr_r;
    assign reg_rd    = reg_rd_r;

    // ****************************************
    // checks
    // ****************************************
    idle_release_a: assert property (@(posedge lnk_clk) disable iff (!rst_n)
        st_r == ST_IDLE |-> !oe_r)
        else $error("data driven while idle");

    start_det_a: assert property (@(posedge lnk_clk) disable iff (!rst_n)
        start_evt |=> st_r == ST_RX && first_r && cnt_r == RTW_CNT_RST)
        else $error("start not taken");

    stop_det_a: assert property (@(posedge lnk_clk) disable iff (!rst_n)
        stop_evt |=> st_r == ST_IDLE && !oe_r)
        else $error("stop not taken");

    byte_cont_a: assert property (@(posedge lnk_clk) disable iff (!rst_n)
        ack_end_rx |=> st_r == ST_RX || st_r == ST_TX)
        else $error("transfer ended after a byte");

    ack_slot_a: assert property (@(posedge lnk_clk) disable iff (!rst_n)
        rx_done && !first_r |=> st_r == ST_RX_ACK && cnt_r == RTW_CNT_RST)
        else $error("no ack slot after eight bits");

    tx_release_a: assert property (@(posedge lnk_clk) disable iff (!rst_n)
        tx_done |=> !oe_r && st_r == ST_TX_ACK)
        else $error("data held during master ack slot");

    ack_drive_a: assert property (@(posedge lnk_clk) disable iff (!rst_n)
        acc_addr |=> (oe_r && !sda_o) throughout (st_r == ST_RX_ACK)[*1])
        else $error("matched address not acknowledged");

    ack_hold_a: assert property (@(posedge lnk_clk) disable iff (!rst_n)
        st_r == ST_RX_ACK && scl_s |-> oe_r)
        else $error("ack released while clock high");

    nack_end_a: assert property (@(posedge lnk_clk) disable iff (!rst_n)
        st_r == ST_TX_ACK && scl_fall && nack_r |=> st_r == ST_IDLE ##1 !oe_r)
        else $error("data not released after withheld ack");

    addr_miss_a: assert property (@(posedge lnk_clk) disable iff (!rst_n)
        rx_done && first_r && !addr_hit |=> st_r == ST_IDLE ##1 !oe_r)
        else $error("foreign address acknowledged");

    idx_low_a: assert property (@(posedge lnk_clk) disable iff (!rst_n)
        rx_idx |=> idx_r == $past(sh_lo))
        else $error("selector not taken from low bits");

    idx_step_a: assert property (@(posedge lnk_clk) disable iff (!rst_n)
        rx_wr || tx_done |=> idx_r == $past(idx_r) + RTW_IDX_STEP)
        else $error("selector did not advance");

    wr_pulse_a: assert property (@(posedge clk) disable iff (!rst_n)
        reg_wr_r |=> !reg_wr_r)
        else $error("write strobe longer than one cycle");

    write_byte_c: cover property (@(posedge lnk_clk) disable iff (!rst_n)
        rx_wr);
    read_byte_c: cover property (@(posedge lnk_clk) disable iff (!rst_n)
        tx_next);
    read_end_c: cover property (@(posedge lnk_clk) disable iff (!rst_n)
        st_r == ST_TX_ACK && scl_fall && nack_r);
    addr_miss_c: cover property (@(posedge lnk_clk) disable iff (!rst_n)
        rx_done && first_r && !addr_hit);

endmodule : rtw_slave_port

/* rtw_bus_master.sv */
// behavioural two-wire bus master facing the slave port
// assumes an open-drain data wire with pull-up, resolved by the bench

module rtw_bus_master (
    input  wire logic clk,
    input  wire logic sda,
    output logic      scl,
    output logic      sda_pull
);
    timeunit 1ns;
    timeprecision 1ps;

    // ****************************************
    // bit timing
    // ****************************************
    localparam int Q = 20;  // quarter bit in clk cycles, low phase is two quarters

    initial begin
        scl      = 1'b1;
        sda_pull = 1'b0;
    end

    task automatic q_wait;
        repeat (Q) @(posedge clk);
    endtask : q_wait

    // ****************************************
    // bus conditions
    // ****************************************
    task automatic start_c;
        sda_pull <= 1'b0;
        q_wait;
        scl      <= 1'b1;
        q_wait;
        sda_pull <= 1'b1;
        q_wait;
        scl      <= 1'b0;
        q_wait;
    endtask : start_c

    task automatic stop_c;
        sda_pull <= 1'b1;
        q_wait;
        scl      <= 1'b1;
        q_wait;
        sda_pull <= 1'b0;
        q_wait;
    endtask : stop_c

    // data changes only with clock low, sampled mid high phase
    task automatic bit_x(input logic b, output logic r);
        sda_pull <= ~b;
        q_wait;
        scl      <= 1'b1;
        q_wait;
        r = sda;
        q_wait;
        scl      <= 1'b0;
        q_wait;
    endtask : bit_x

    // eight bits msb first then one acknowledge slot
    task automatic xfer(input logic [7:0] d, input logic ack_in, output logic [7:0] rd, output logic ak);
        for (int i = 7; i >= 0; i--) begin
            bit_x(d[i], rd[i]);
        end
        bit_x(ack_in, ak);
    endtask : xfer

endmodule : rtw_bus_master

/* tb_rtw_slave_port.sv */
// self-checking bench for the two-wire slave port
// assumes rtw_pkg, rtw_slave_port and rtw_bus_master are compiled first

module tb_rtw_slave_port;
    timeunit 1ns;
    timeprecision 1ps;
    import rtw_pkg::*;

    logic       clk       = 1'b0;
    logic       lnk_clk   = 1'b0;
    logic       rst_n     = 1'b0;
    logic       scl;
    logic       sda_pull;
    logic       sda_o;
    logic       sda_oe;
    logic       ce        = 1'b1;
    wire logic  sda       = ~sda_pull & (~sda_oe | sda_o);
    logic [3:0] reg_idx;
    logic [7:0] reg_wdata;
    logic       reg_wr;
    logic       reg_rd;
    logic [7:0] reg_rdata = 8'h00;
    logic [7:0] mem [16];
    int         n_wr      = 0;
    int         n_errors  = 0;
    int         compares  = 0;
    logic [7:0] rd;
    logic       ak;
    logic [7:0] wa;
    logic [7:0] ra;

    always #2 clk = ~clk;
    always #3 lnk_clk = ~lnk_clk;

    rtw_slave_port u_rtw_slave_port (
        .clk       (clk),
        .rst_n     (rst_n),
        .ce        (ce),
        .lnk_clk   (lnk_clk),
        .scl_i     (scl),
        .sda_i     (sda),
        .sda_o     (sda_o),
        .sda_oe    (sda_oe),
        .reg_idx   (reg_idx),
        .reg_wdata (reg_wdata),
        .reg_wr    (reg_wr),
        .reg_rd    (reg_rd),
        .reg_rdata (reg_rdata)
    );

    rtw_bus_master u_rtw_bus_master (
        .clk      (clk),
        .sda      (sda),
        .scl      (scl),
        .sda_pull (sda_pull)
    );

    // ****************************************
    // register side model, one cycle read latency
    // ****************************************
    always @(posedge clk) begin
        if (reg_wr === 1'b1) begin
            mem[reg_idx] <= reg_wdata;
            n_wr         <= n_wr + 1;
        end
        if (reg_rd === 1'b1) begin
            reg_rdata <= mem[reg_idx];
        end
    end

    // ****************************************
    // checking and closing
    // ****************************************
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic wrap_up;
        $display("compares %0d mismatches %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : wrap_up

    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_write;
        int wr0;
        wr0 = n_wr;
        u_rtw_bus_master.start_c;
        u_rtw_bus_master.xfer(wa, 1'b1, rd, ak);
        chk("addr ack", 8'h00, {7'h00, ak});
        u_rtw_bus_master.xfer(8'hfe, 1'b1, rd, ak);
        chk("sel ack", 8'h00, {7'h00, ak});
        u_rtw_bus_master.xfer(8'h5a, 1'b1, rd, ak);
        chk("data0 ack", 8'h00, {7'h00, ak});
        u_rtw_bus_master.xfer(8'ha5, 1'b1, rd, ak);
        chk("data1 ack", 8'h00, {7'h00, ak});
        u_rtw_bus_master.xfer(8'h3c, 1'b1, rd, ak);
        chk("data2 ack", 8'h00, {7'h00, ak});
        u_rtw_bus_master.stop_c;
        chk("writes", 8'h03, 8'(n_wr - wr0));
        chk("mem e", 8'h5a, mem[14]);
        chk("mem f", 8'ha5, mem[15]);
        chk("mem 0", 8'h3c, mem[0]);
        chk("idle drive", 8'h00, {7'h00, sda_oe});
        $display("t_write done");
    endtask : t_write

    task automatic t_read;
        u_rtw_bus_master.start_c;
        u_rtw_bus_master.xfer(wa, 1'b1, rd, ak);
        chk("addr ack", 8'h00, {7'h00, ak});
        u_rtw_bus_master.xfer(8'h2e, 1'b1, rd, ak);
        chk("sel ack", 8'h00, {7'h00, ak});
        u_rtw_bus_master.start_c;
        u_rtw_bus_master.xfer(ra, 1'b1, rd, ak);
        chk("raddr ack", 8'h00, {7'h00, ak});
        u_rtw_bus_master.xfer(8'hff, 1'b0, rd, ak);
        chk("rd e", 8'h5a, rd);
        u_rtw_bus_master.xfer(8'hff, 1'b0, rd, ak);
        chk("rd f", 8'ha5, rd);
        u_rtw_bus_master.xfer(8'hff, 1'b1, rd, ak);
        chk("rd 0", 8'h3c, rd);
        chk("nack seen", 8'h01, {7'h00, ak});
        chk("nack release", 8'h00, {7'h00, sda_oe});
        u_rtw_bus_master.stop_c;
        chk("idle drive", 8'h00, {7'h00, sda_oe});
        $display("t_read done");
    endtask : t_read

    task automatic t_other_addr;
        int wr0;
        wr0 = n_wr;
        u_rtw_bus_master.start_c;
        u_rtw_bus_master.xfer({RTW_DEV_ADDR ^ 7'h01, 1'b0}, 1'b1, rd, ak);
        chk("foreign ack", 8'h01, {7'h00, ak});
        u_rtw_bus_master.xfer(8'h01, 1'b1, rd, ak);
        chk("foreign data ack", 8'h01, {7'h00, ak});
        u_rtw_bus_master.stop_c;
        chk("foreign writes", 8'h00, 8'(n_wr - wr0));
        chk("mem 0 kept", 8'h3c, mem[0]);
        $display("t_other_addr done");
    endtask : t_other_addr

    // clock enable low: bus ignored, then normal answer again
    task automatic t_freeze;
        @(posedge clk);
        ce <= 1'b0;
        repeat (4) @(posedge clk);
        u_rtw_bus_master.start_c;
        u_rtw_bus_master.xfer(wa, 1'b1, rd, ak);
        chk("frozen ack", 8'h01, {7'h00, ak});
        u_rtw_bus_master.stop_c;
        ce <= 1'b1;
        repeat (4) @(posedge clk);
        u_rtw_bus_master.start_c;
        u_rtw_bus_master.xfer(wa, 1'b1, rd, ak);
        chk("thawed ack", 8'h00, {7'h00, ak});
        u_rtw_bus_master.stop_c;
        chk("thawed idle", 8'h00, {7'h00, sda_oe});
        $display("t_freeze done");
    endtask : t_freeze

    // ****************************************
    // main sequence and watchdog
    // ****************************************
    initial begin
        wa = {RTW_DEV_ADDR, 1'b0};
        ra = {RTW_DEV_ADDR, 1'b1};
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        repeat (10) @(posedge clk);
        t_write;
        t_read;
        t_other_addr;
        t_freeze;
        wrap_up;
    end

    initial begin
        repeat (60000) @(posedge clk);
        n_errors++;
        $display("[ERR] watchdog expected finish seen hang");
        wrap_up;
    end

endmodule : tb_rtw_slave_port
